/* File: htg_cfg.svh */
// Constants of the host transaction gateway: widths, sizes and codes.
// Assumes inclusion by the gateway package, the gateway module and the testbench.
//
// Function
// - After a doorbell write with a 16-byte aligned address the gateway fetches the control block by DMA and then interrupts the local processor.
// - One transaction is fetched at a time and doorbells written while busy are dropped; completions name any block, in the order the processor gives them.
// - On completion the gateway writes a pointer to the control block into the host reply queue by DMA.
// - Every reply queue entry carries a tag marking the transaction as completed.
// - On completion the host interrupt is raised only after the completion pointer has been written; a host bus abort or an internal fault also raises it.
// - A disk command that fails after all recovery completes its transaction with a non-success result code.
// - An internal fault halts execution, records an adapter error and raises the host interrupt, leaving work uncompleted.
// - A host bus error ends the cycle with a target or master abort and the transaction is not completed.
// - Write data is fetched from host memory by DMA for the disk and read data is stored to host memory by DMA.
// - Data DMA supports scatter and gather over several noncontiguous host memory regions.
`ifndef HTG_CFG_SVH
`define HTG_CFG_SVH

`define HTG_ADDR_W        32
`define HTG_DATA_W        32
`define HTG_BLOCK_BYTES   128
`define HTG_BLOCK_WORDS   32
`define HTG_BLOCK_ALIGN   16
`define HTG_ALIGN_BITS    4
`define HTG_QDEPTH        8
`define HTG_QPTR_W        3
`define HTG_DONE_TAG      2'h1
`define HTG_TAG_BITS      2
`define HTG_SUCCESS_CODE  8'h00
`define HTG_FAIL_CODE     8'h01
`define HTG_ERR_ALIGN     8'h01
`define HTG_ERR_ABORT     8'h02
`define HTG_ERR_INTERNAL  8'h03

`endif

/* File: htg_pkg.sv */
// Types shared by the host transaction gateway.
// Assumes htg_cfg.svh is on the include path.
`include "htg_cfg.svh"

package htg_pkg;

  typedef enum logic [2:0] {
    HTG_IDLE,
    HTG_FETCH,
    HTG_CPU,
    HTG_DATA,
    HTG_REPLY,
    HTG_HALT
  } htg_state_t;

  typedef struct packed {
    htg_state_t                  st;
    logic [`HTG_ADDR_W-1:0]      blk_addr;
    logic [5:0]                  word_cnt;
    logic [`HTG_ADDR_W-1:0]      dma_addr;
    logic                        dma_req;
    logic                        dma_wr;
    logic [`HTG_DATA_W-1:0]      dma_wdata;
    logic [`HTG_ADDR_W-1:0]      seg_addr;
    logic [15:0]                 seg_left;
    logic                        data_wr;
    logic [`HTG_DATA_W-1:0]      blk_data;
    logic                        blk_valid;
    logic                        cpu_irq;
    logic                        host_irq;
    logic                        halted;
    logic [7:0]                  err_code;
    logic                        busy;
    logic [7:0]                  result;
    logic                        disk_ack;
    logic [`HTG_DATA_W-1:0]      disk_rdata;
    logic                        disk_rvalid;
  } htg_regs_t;

endpackage

/* File: htg_gateway.sv */
// Host transaction gateway: doorbell intake, control block fetch, data DMA with
// scatter/gather segments, tagged completion write into the host reply queue.
// Assumes a simple word DMA master port toward the host bus that reports abort.
`timescale 1ns/1ps
`include "htg_cfg.svh"

module htg_gateway
  import htg_pkg::*;
#(
  parameter int QDEPTH = `HTG_QDEPTH
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // Request doorbell from the host
  input  wire logic                   request_doorbell_wr,
  input  wire logic [`HTG_ADDR_W-1:0] request_doorbell_data,
  // DMA master toward host memory
  output logic                        dma_req,
  output logic                        dma_wr,
  output logic [`HTG_ADDR_W-1:0]      dma_addr,
  output logic [`HTG_DATA_W-1:0]      dma_wdata,
  input  wire logic                   dma_done,
  input  wire logic [`HTG_DATA_W-1:0] dma_rdata,
  input  wire logic                   dma_target_abort,
  input  wire logic                   dma_master_abort,
  // Control block words toward the local processor
  output logic [`HTG_DATA_W-1:0]      blk_data,
  output logic                        blk_valid,
  output logic                        cpu_irq,
  input  wire logic                   cpu_irq_ack,
  // Data segment commands from the local processor
  input  wire logic                   seg_start,
  input  wire logic [`HTG_ADDR_W-1:0] seg_host_addr,
  input  wire logic [15:0]            seg_words,
  input  wire logic                   seg_to_host,
  // Disk side data words
  input  wire logic                   disk_wvalid,
  input  wire logic [`HTG_DATA_W-1:0] disk_wdata,
  output logic                        disk_ack,
  output logic [`HTG_DATA_W-1:0]      disk_rdata,
  output logic                        disk_rvalid,
  // Completion from the local processor
  input  wire logic                   done_valid,
  input  wire logic [`HTG_ADDR_W-1:0] done_block,
  input  wire logic                   done_failed,
  input  wire logic                   internal_fault,
  // Host reply queue and status
  input  wire logic [`HTG_ADDR_W-1:0] reply_queue_base,
  output logic                        host_irq,
  output logic                        halted,
  output logic [7:0]                  err_code,
  output logic [7:0]                  result,
  output logic                        busy
);

  htg_regs_t q;
  htg_regs_t d;
  logic [`HTG_QPTR_W-1:0] qwr_q;
  logic [`HTG_QPTR_W-1:0] qwr_d;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic aligned(input logic [`HTG_ADDR_W-1:0] a);
    aligned = (a[`HTG_ALIGN_BITS-1:0] == '0);
  endfunction

  function automatic logic [`HTG_ADDR_W-1:0] reply_entry(input logic [`HTG_ADDR_W-1:0] a);
    reply_entry = {a[`HTG_ADDR_W-1:`HTG_TAG_BITS], `HTG_DONE_TAG};
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    qwr_d = qwr_q;
    d.blk_valid = 1'b0;
    d.disk_ack = 1'b0;
    d.disk_rvalid = 1'b0;
    if (cpu_irq_ack) begin
      d.cpu_irq = 1'b0;
    end
    if (q.dma_req && (dma_target_abort || dma_master_abort)) begin
      // The aborted transfer is dropped and no completion is written.
      d.dma_req = 1'b0;
      d.err_code = `HTG_ERR_ABORT;
      d.host_irq = 1'b1;
      d.st = HTG_IDLE;
      d.busy = 1'b0;
    end else begin
      case (q.st)
        HTG_IDLE: begin
          // A doorbell is taken only here in idle, never while other work runs, and it wins over seg_start and done_valid.
          if (request_doorbell_wr) begin
            if (aligned(request_doorbell_data)) begin
              d.blk_addr = request_doorbell_data;
              d.dma_addr = request_doorbell_data;
              d.word_cnt = '0;
              d.dma_req = 1'b1;
              d.dma_wr = 1'b0;
              d.busy = 1'b1;
              d.st = HTG_FETCH;
            end else begin
              d.err_code = `HTG_ERR_ALIGN;
            end
          end else if (seg_start) begin
            d.seg_addr = seg_host_addr;
            d.seg_left = seg_words;
            d.data_wr = seg_to_host;
            d.busy = 1'b1;
            d.st = HTG_DATA;
          end else if (done_valid) begin
            d.dma_addr = reply_queue_base + {{(`HTG_ADDR_W-`HTG_QPTR_W-2){1'b0}}, qwr_q, 2'b00};
            d.dma_wdata = reply_entry(done_block);
            d.result = done_failed ? `HTG_FAIL_CODE : `HTG_SUCCESS_CODE;
            d.dma_wr = 1'b1;
            d.dma_req = 1'b1;
            d.busy = 1'b1;
            d.st = HTG_REPLY;
          end
        end
        HTG_FETCH: begin
          if (dma_done) begin
            d.blk_data = dma_rdata;
            d.blk_valid = 1'b1;
            if (q.word_cnt == 6'(`HTG_BLOCK_WORDS - 1)) begin
              d.dma_req = 1'b0;
              d.cpu_irq = 1'b1;
              d.st = HTG_CPU;
            end else begin
              d.word_cnt = q.word_cnt + 6'h01;
              d.dma_addr = q.dma_addr + 32'h4;
            end
          end
        end
        HTG_CPU: begin
          d.busy = 1'b0;
          d.st = HTG_IDLE;
        end
        HTG_DATA: begin
          if (q.seg_left == '0) begin
            d.dma_req = 1'b0;
            d.busy = 1'b0;
            d.st = HTG_IDLE;
          end else if (!q.dma_req) begin
            if (q.data_wr && disk_wvalid) begin
              d.dma_wdata = disk_wdata;
              d.disk_ack = 1'b1;
              d.dma_addr = q.seg_addr;
              d.dma_wr = 1'b1;
              d.dma_req = 1'b1;
            end else if (!q.data_wr) begin
              d.dma_addr = q.seg_addr;
              d.dma_wr = 1'b0;
              d.dma_req = 1'b1;
            end
          end else if (dma_done) begin
            d.dma_req = 1'b0;
            d.seg_addr = q.seg_addr + 32'h4;
            d.seg_left = q.seg_left - 16'h0001;
            if (!q.data_wr) begin
              d.disk_rdata = dma_rdata;
              d.disk_rvalid = 1'b1;
            end
          end
        end
        HTG_REPLY: begin
          if (dma_done) begin
            d.dma_req = 1'b0;
            qwr_d = qwr_q + 3'h1;
            d.host_irq = 1'b1;
            d.busy = 1'b0;
            d.st = HTG_IDLE;
          end
        end
        HTG_HALT: begin
          // Only reset leaves this state; doorbells are dropped.
          d.busy = 1'b0;
        end
        default: d.st = HTG_IDLE;
      endcase
    end
    if (internal_fault && q.st != HTG_HALT) begin
      d.st = HTG_HALT;
      d.halted = 1'b1;
      d.err_code = `HTG_ERR_INTERNAL;
      d.host_irq = 1'b1;
      d.dma_req = 1'b0;
      d.busy = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= HTG_IDLE;
      q.result <= `HTG_SUCCESS_CODE;
      qwr_q <= '0;
    end else begin
      q <= d;
      qwr_q <= qwr_d;
    end
  end

  assign dma_req     = q.dma_req;
  assign dma_wr      = q.dma_wr;
  assign dma_addr    = q.dma_addr;
  assign dma_wdata   = q.dma_wdata;
  assign blk_data    = q.blk_data;
  assign blk_valid   = q.blk_valid;
  assign cpu_irq     = q.cpu_irq;
  assign disk_ack    = q.disk_ack;
  assign disk_rdata  = q.disk_rdata;
  assign disk_rvalid = q.disk_rvalid;
  assign host_irq    = q.host_irq;
  assign halted      = q.halted;
  assign err_code    = q.err_code;
  assign result      = q.result;
  assign busy        = q.busy;

endmodule

/* File: htg_gateway_sva.sv */
// Port checker of the host transaction gateway, bound to every instance.
// Assumes the reply queue base is aligned to 32 bytes, away from data regions.
`timescale 1ns/1ps

module htg_chk (
  // Clock, reset and requests
  input wire logic        mclk, rst_n, request_doorbell_wr, internal_fault, done_valid, done_failed,
  input wire logic [31:0] request_doorbell_data, done_block, reply_queue_base,
  // DMA, local side and status
  input wire logic        dma_req, dma_wr, dma_done, dma_target_abort, dma_master_abort, blk_valid,
  input wire logic        cpu_irq, disk_rvalid, host_irq, halted, busy,
  input wire logic [31:0] dma_addr, dma_wdata, dma_rdata, blk_data, disk_rdata,
  input wire logic [7:0]  err_code, result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic        fail_q, wr_done_q;
  logic [29:0] blk_q;
  wire         take_db = request_doorbell_wr && !busy && !halted;
  wire         take_done = done_valid && !busy && !halted && !request_doorbell_wr;

  always_ff @(posedge mclk) begin
    wr_done_q <= dma_done && dma_wr;
    if (take_done) begin
      fail_q <= done_failed;
      blk_q  <= done_block[31:2];
    end
  end

  sequence s_reply_issue;
    dma_req && dma_wr && dma_addr[31:5] == reply_queue_base[31:5] && dma_wdata[1:0] == 2'b01;
  endsequence

  a_fetch_start: assert property (take_db && request_doorbell_data[3:0] == 4'h0 |=>
    dma_req && !dma_wr && dma_addr == $past(request_doorbell_data)) else $error("fetch not started");
  a_align_refuse: assert property (take_db && request_doorbell_data[3:0] != 4'h0 |=>
    !dma_req && err_code == 8'h01) else $error("misaligned block fetched");
  a_word_fwd: assert property (blk_valid |-> $past(dma_done) && blk_data == $past(dma_rdata))
    else $error("block word wrong");
  a_cpu_irq_late: assert property ($rose(cpu_irq) |-> $past(dma_done) && blk_valid)
    else $error("processor interrupt early");
  a_reply_write: assert property (take_done |=> s_reply_issue ##0 dma_wdata[31:2] == blk_q)
    else $error("reply entry wrong");
  a_irq_after: assert property ($rose(host_irq) |-> halted || err_code != 8'h00 || wr_done_q)
    else $error("host interrupt before reply");
  a_result_code: assert property ($rose(host_irq) && err_code == 8'h00 |-> result == {7'h0, fail_q})
    else $error("result code wrong");
  a_fault_halt: assert property (internal_fault |=> halted && host_irq && err_code == 8'h03)
    else $error("fault not recorded");
  a_halt_hold: assert property (halted |=> halted && !dma_req)
    else $error("halt left");
  a_abort_drop: assert property ((dma_target_abort || dma_master_abort) && dma_req |=>
    (!dma_req && !cpu_irq && err_code == 8'h02)[*2]) else $error("abort not handled");
  a_disk_fwd: assert property (disk_rvalid |-> $past(dma_done) && disk_rdata == $past(dma_rdata))
    else $error("disk word wrong");
endmodule

bind htg_gateway htg_chk u_htg_chk (.*);

/* File: htg_host_mem.sv */
// Host memory model answering the gateway's DMA master port.
// Assumes one access at a time; reads return the inverted address.
`timescale 1ns/1ps

module htg_host_mem (
  // Clock, reset and bench controls
  input wire logic        mclk, rst_n, slow,
  input wire logic [1:0]  abort_cmd,
  // DMA port
  input wire logic        dma_req, dma_wr,
  input wire logic [31:0] dma_addr, dma_wdata,
  output logic            dma_done, dma_target_abort, dma_master_abort,
  output logic [31:0]     dma_rdata, wr_addr, wr_data
);
  logic [1:0] wait_q;
  wire        fire = dma_req && !dma_done && !dma_target_abort && !dma_master_abort && (wait_q == 2'h3 || !slow);

  always @(posedge mclk) begin
    dma_done         <= rst_n && fire && abort_cmd == 2'h0;
    dma_target_abort <= rst_n && fire && abort_cmd == 2'h1;
    dma_master_abort <= rst_n && fire && abort_cmd == 2'h2;
    wait_q           <= rst_n && dma_req && !fire ? wait_q + 2'h1 : 2'h0;
    dma_rdata        <= !rst_n ? 32'h0 : fire && !dma_wr ? ~dma_addr : ~dma_rdata;
    if (fire && dma_wr) begin
      wr_addr <= dma_addr;
      wr_data <= dma_wdata;
    end
  end
endmodule

/* File: htg_gateway_tb.sv */
// Self-checking bench of the host transaction gateway with its host memory model.
// Assumes htg_cfg.svh on the include path and the model's inverted-address read data.
`timescale 1ns/1ps
`include "htg_cfg.svh"

module htg_gateway_tb;
  logic        mclk, rst_n, request_doorbell_wr, cpu_irq_ack, seg_start, seg_to_host, disk_wvalid, done_valid;
  logic        done_failed, internal_fault, slow, dma_req, dma_wr, dma_done, dma_target_abort, dma_master_abort;
  logic        blk_valid, cpu_irq, disk_ack, disk_rvalid, host_irq, halted, busy;
  logic [1:0]  abort_cmd;
  logic [7:0]  err_code, result;
  logic [15:0] seg_words;
  logic [31:0] request_doorbell_data, seg_host_addr, disk_wdata, done_block, reply_queue_base, dma_addr;
  logic [31:0] dma_wdata, dma_rdata, blk_data, disk_rdata, wr_addr, wr_data, cur;
  int          miscompares, total_checks, k, rk, ak;
  logic [40:0] rows [3] = '{{32'h0000_1000, 1'b0, 8'h00}, {32'h0000_2ff0, 1'b1, 8'h01}, {32'h0001_0010, 1'b0, 8'h00}};

  htg_gateway  u_htg_gateway (.*);
  htg_host_mem u_htg_host_mem (.*);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Waits for the processor interrupt (s=0) or for idle (s=1).
  task automatic waitc(input int s);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(s == 0 ? cpu_irq === 1'b1 : busy === 1'b0) && n < 3000);
    if (n >= 3000) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic rst();
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic ring(input logic [31:0] a);
    cur = a;
    k = 0;
    request_doorbell_wr   <= 1'b1;
    request_doorbell_data <= a;
    @(posedge mclk);
    request_doorbell_wr <= 1'b0;
  endtask

  task automatic seg(input logic [31:0] a, input logic [15:0] n, input logic th);
    rk = 0;
    seg_start     <= 1'b1;
    seg_host_addr <= a;
    seg_words     <= n;
    seg_to_host   <= th;
    @(posedge mclk);
    seg_start <= 1'b0;
    waitc(1);
    @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    if (blk_valid === 1'b1) begin
      chk(blk_data, ~(cur + 32'(4 * k)));
      k++;
    end
    if (disk_ack === 1'b1) ak++;
    if (disk_rvalid === 1'b1) begin
      chk(disk_rdata, ~(seg_host_addr + 32'(4 * rk)));
      rk++;
    end
  end

  initial begin
    {rst_n, request_doorbell_wr, cpu_irq_ack, seg_start, seg_to_host, done_valid, done_failed} = '0;
    {internal_fault, slow, abort_cmd, seg_words, request_doorbell_data, seg_host_addr, done_block} = '0;
    {miscompares, total_checks, k, rk, ak, cur} = '0;
    disk_wvalid = 1'b1;
    disk_wdata = 32'hc3a5_0f96;
    reply_queue_base = 32'h0008_0000;
    rst();
    chk({dma_req, cpu_irq, host_irq, halted, busy, err_code}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      slow <= i[0];
      ring(rows[i % 3][40:9]);
      waitc(0);
      @(posedge mclk);
      chk(k, 32);
      cpu_irq_ack <= 1'b1;
      @(posedge mclk);
      cpu_irq_ack <= 1'b0;
      waitc(1);
      done_valid  <= 1'b1;
      done_block  <= rows[i % 3][40:9];
      done_failed <= rows[i % 3][8];
      @(posedge mclk);
      done_valid <= 1'b0;
      waitc(1);
      chk(wr_addr, reply_queue_base + 32'(4 * (i % 8)));
      chk(wr_data, {rows[i % 3][40:11], 2'b01});
      chk(result, rows[i % 3][7:0]);
      chk(host_irq, 1'b1);
    end
    seg(32'h0004_0000, 16'h2, 1'b1);
    chk(wr_addr, 32'h0004_0004);
    chk(wr_data, disk_wdata);
    chk(ak, 2);
    seg(32'h0006_0100, 16'h3, 1'b0);
    chk(rk, 3);
    ring(32'h0000_3004);
    repeat (3) @(posedge mclk);
    chk({dma_req, err_code}, {1'b0, `HTG_ERR_ALIGN});
    for (int j = 1; j < 3; j++) begin
      rst();
      abort_cmd <= j[1:0];
      ring(32'h0000_5000);
      waitc(1);
      chk({cpu_irq, host_irq, err_code}, {2'b01, `HTG_ERR_ABORT});
    end
    rst();
    abort_cmd      <= 2'h0;
    internal_fault <= 1'b1;
    @(posedge mclk);
    internal_fault <= 1'b0;
    ring(32'h0000_6000);
    repeat (4) @(posedge mclk);
    chk({halted, host_irq, dma_req, err_code}, {3'b110, `HTG_ERR_INTERNAL});
    rst();
    chk({halted, host_irq}, 2'b00);
    finish_test();
  end
endmodule
